// ===== inc/pwa_pkg.sv
package pwa_pkg;
   // register byte offsets on the plain register port
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STAT = 4'h4;

   // control register fields
   localparam int          CTRL_OP_LSB = 0;   // pixel op select, 3 bits
   localparam int          CTRL_WP_LSB = 4;   // plane write protect, 4 bits
   localparam int          CTRL_SH_LSB = 12;  // shifter control, 4 bits
   localparam logic [15:0] CTRL_RST    = 16'h0000;

   // status register fields
   localparam int STAT_BUSY    = 0;
   localparam int STAT_RMW     = 1;
   localparam int STAT_PIX_LSB = 4;

   // shifter control field bits
   localparam int SH_TEST = 3;  // set: test modes
   localparam int SH_DIR  = 2;  // set: shift right

   // pixel constants
   localparam logic [3:0] PIX_ZERO = 4'h0;
   localparam logic [3:0] PIX_FIVE = 4'h5;
   localparam logic [3:0] PIX_TEN  = 4'hA;
   localparam logic [3:0] PIX_C    = 4'hC;
   localparam logic [3:0] PIX_3    = 4'h3;
   localparam logic [3:0] PIX_ONES = 4'hF;

   // pixel op modes, high bit selects constant fill
   typedef enum logic [2:0] {
      OP_REPL = 3'h0,
      OP_XOR  = 3'h1,
      OP_OR   = 3'h2,
      OP_AND  = 3'h3,
      OP_ZERO = 3'h4,
      OP_FIVE = 3'h5,
      OP_TEN  = 3'h6,
      OP_ONES = 3'h7
   } pwa_op_t;

   // memory sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ROW  = 3'h1,
      ST_RD   = 3'h2,
      ST_LAT  = 3'h3,
      ST_WR   = 3'h4,
      ST_SCR  = 3'h5,
      ST_END  = 3'h6
   } pwa_state_t;

   // processor graphics memory request
   typedef struct packed {
      logic        wr;     // write, else read
      logic        word;   // word write, all 16 pixels
      logic        bank;   // high bank
      logic [3:0]  idx;    // pixel in word, bit0 is odd byte
      logic [15:0] wdata;  // processor data word
   } pwa_req_t;

   // strobe generator control
   typedef struct packed {
      logic       act;  // cycle active
      logic       all;  // every strobe
      logic [3:0] idx;  // one pixel ram
   } pwa_stb_ctl_t;
endpackage

// ===== rtl/pwa_strobe_gen.sv
`timescale 1ns/10ps
module pwa_strobe_gen (
   input  wire logic                  clk_sys,
   input  wire logic                  resetn,
   input  wire pwa_pkg::pwa_stb_ctl_t ctl,
   output logic [3:0]                 ras_n,
   output logic [3:0]                 cas_n
);
   // active-low one-hot of a 2-bit select
   function automatic logic [3:0] sel_n(input logic [1:0] s);
      sel_n = ~(4'h1 << s);
   endfunction

   // registered row/column strobes
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         ras_n <= 4'hF;
         cas_n <= 4'hF;
      end else if (!ctl.act) begin
         // idle, nothing selected
         ras_n <= 4'hF;
         cas_n <= 4'hF;
      end else if (ctl.all) begin
         // whole word: refresh or word write
         ras_n <= 4'h0; // RQ15 RQ17
         cas_n <= 4'h0; // RQ15 RQ17
      end else begin
         // row by idx high, column by idx low: one ram of 16
         ras_n <= sel_n(ctl.idx[3:2]); // RQ16
         cas_n <= sel_n(ctl.idx[1:0]); // RQ16
      end
   end
endmodule

// ===== rtl/pwa_datapath.sv
`timescale 1ns/10ps
// Operation
// RQ1: replace, no protect: write-only cycle
// RQ2: protect or logic op: read-modify-write
// RQ3: three-bit mode picks eight pixel ops
// RQ4: low modes: replace, xor, or, and
// RQ5: high modes: fill 0, 5, A, F
// RQ6: protected planes keep stored bit; a word write puts the stored bit of pixel idx into all 16 rams
// RQ7: read pixel latched by enable clock
// RQ8: pixel on low nibble both bytes
// RQ9: upper nibble of each byte zero
// RQ10: even takes low byte, odd high
// RQ11: shifter bits 12-15, bit15 test
// RQ12: normal: shift new data, old unchanged
// RQ13: test codes 8-B force new/old
// RQ14: test codes C-F: ones, A/5/C/3
// RQ15: refresh asserts every row and column
// RQ16: byte access selects exactly one ram
// RQ17: word write asserts all strobes
// RQ18: sequencer drives strobe and enable generators
// RQ19: screen bank select; rmw request
// RQ20: low address bits steer read mux
// RQ21: alu bit replicated across plane
// RQ22: protect applied per plane bit
module pwa_datapath (
   input  wire logic              clk_sys,
   input  wire logic              resetn,
   // register port
   input  wire logic [3:0]        reg_addr,
   input  wire logic [15:0]       reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic [15:0]            reg_rdata,
   // processor graphics memory port
   input  wire logic              mem_req,
   input  wire pwa_pkg::pwa_req_t mem_cmd,
   output logic                   mem_busy,
   output logic [15:0]            mem_rdata,
   output logic                   mem_rvalid,
   // screen refresh request
   input  wire logic              scr_req,
   input  wire logic              scr_bank,
   output logic                   disp_load,
   // ram array side
   input  wire logic [63:0]       ram_rdata,
   output logic [63:0]            ram_wdata,
   output logic [3:0]             ram_ras_n,
   output logic [3:0]             ram_cas_n,
   output logic                   ram_we_n,
   output logic                   ram_oe_n,
   output logic                   low_bank_select,
   output logic                   high_bank_select,
   output logic                   rmw_request
);
   // control register and its fields
   logic [15:0]         ctrl_r;     // software control word
   logic [2:0]          op_sel;     // pixel op select
   logic [3:0]          wprot;      // plane write protects
   logic [3:0]          shifter_ctl; // shifter mode

   // sequencer
   pwa_pkg::pwa_state_t state_r;    // current state
   pwa_pkg::pwa_state_t state_nxt;  // next state
   pwa_pkg::pwa_req_t   req_r;      // captured request
   logic                rmw_r;      // cycle needs a read first
   logic                rmw_nxt;    // decision for new request
   logic                take_req;   // request accepted now
   logic                take_scr;   // screen cycle starts now

   // data path
   logic [3:0]          rd_pix_r;   // read data latch
   logic [3:0]          mux_pix;    // 16-to-1 read mux output
   logic [3:0]          new_pix;    // shifted processor pixel
   logic [3:0]          old_pix;    // shifter view of old pixel
   logic [3:0]          alu_out;    // op result
   logic [3:0]          wr_pix;     // after plane protection
   logic [7:0]          wr_byte;    // selected processor byte
   logic                lat_en;     // latch clock from enable gen
   logic [3:0]          old_raw;    // latch output view

   // strobe generator control
   pwa_pkg::pwa_stb_ctl_t stb_ctl;

   // register fields
   assign op_sel      = ctrl_r[pwa_pkg::CTRL_OP_LSB +: 3]; // RQ3
   assign wprot       = ctrl_r[pwa_pkg::CTRL_WP_LSB +: 4];
   assign shifter_ctl = ctrl_r[pwa_pkg::CTRL_SH_LSB +: 4]; // RQ11

   // processor data shifter for new pixel
   function automatic logic [3:0] shift_new(input logic [3:0] d,
                                            input logic [3:0] c);
      logic [1:0] n;
      n = c[1:0];
      if (!c[pwa_pkg::SH_TEST]) begin
         // normal: direction bit, count in low bits
         if (c[pwa_pkg::SH_DIR])
            shift_new = d >> n; // RQ12
         else
            shift_new = d << n; // RQ12
      end else if (c[2:1] == 2'b00) begin
         // codes 1000, 1001 write zeros
         shift_new = pwa_pkg::PIX_ZERO; // RQ13
      end else begin
         // codes 1010 to 1111 write ones
         shift_new = pwa_pkg::PIX_ONES; // RQ13 RQ14
      end
   endfunction

   // data shifter view of old pixel
   function automatic logic [3:0] shift_old(input logic [3:0] d,
                                            input logic [3:0] c);
      unique case (c)
         4'h9:    shift_old = pwa_pkg::PIX_ONES; // RQ13
         4'hB:    shift_old = pwa_pkg::PIX_ZERO; // RQ13
         4'hC:    shift_old = pwa_pkg::PIX_TEN;  // RQ14
         4'hD:    shift_old = pwa_pkg::PIX_FIVE; // RQ14
         4'hE:    shift_old = pwa_pkg::PIX_C;    // RQ14
         4'hF:    shift_old = pwa_pkg::PIX_3;    // RQ14
         // normal codes and 1000, 1010 pass old data
         default: shift_old = d; // RQ12 RQ13
      endcase
   endfunction

   // eight pixel operations
   function automatic logic [3:0] pix_op(input logic [2:0] m,
                                         input logic [3:0] nw,
                                         input logic [3:0] od);
      unique case (pwa_pkg::pwa_op_t'(m))
         pwa_pkg::OP_REPL: pix_op = nw;      // RQ4
         pwa_pkg::OP_XOR:  pix_op = od ^ nw; // RQ4
         pwa_pkg::OP_OR:   pix_op = od | nw; // RQ4
         pwa_pkg::OP_AND:  pix_op = od & nw; // RQ4
         pwa_pkg::OP_ZERO: pix_op = pwa_pkg::PIX_ZERO; // RQ5
         pwa_pkg::OP_FIVE: pix_op = pwa_pkg::PIX_FIVE; // RQ5
         pwa_pkg::OP_TEN:  pix_op = pwa_pkg::PIX_TEN;  // RQ5
         pwa_pkg::OP_ONES: pix_op = pwa_pkg::PIX_ONES; // RQ5
      endcase
   endfunction

   // read-first decision for a write
   function automatic logic need_read(input logic [2:0] m,
                                      input logic [3:0] p);
      // logic ops or any protect force a read
      need_read = (p != 4'h0) || (m == pwa_pkg::OP_XOR) ||
                  (m == pwa_pkg::OP_OR) || (m == pwa_pkg::OP_AND); // RQ1 RQ2
   endfunction

   // request acceptance, screen cycles win in idle
   assign take_scr = (state_r == pwa_pkg::ST_IDLE) && scr_req;
   assign take_req = (state_r == pwa_pkg::ST_IDLE) && !scr_req && mem_req;
   // reads always read, writes per mode and protects
   assign rmw_nxt  = mem_cmd.wr && need_read(op_sel, wprot);

   // register writes
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         ctrl_r <= pwa_pkg::CTRL_RST;
      end else if (reg_wr && reg_addr == pwa_pkg::REG_CTRL) begin
         ctrl_r <= reg_wdata;
      end
   end

   // register reads, data only in the cycle after the strobe
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd && reg_addr == pwa_pkg::REG_CTRL) begin
         reg_rdata <= ctrl_r;
      end else if (reg_rd && reg_addr == pwa_pkg::REG_STAT) begin
         // busy, read-first flag, latched pixel
         reg_rdata <= {8'h00, rd_pix_r, 2'b00, rmw_r,
                       state_r != pwa_pkg::ST_IDLE};
      end else begin
         // unmapped or no read: zero
         reg_rdata <= 16'h0000;
      end
   end

   // sequencer next state
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         pwa_pkg::ST_IDLE: begin
            if (take_scr)
               state_nxt = pwa_pkg::ST_SCR;
            else if (take_req)
               state_nxt = pwa_pkg::ST_ROW;
         end
         pwa_pkg::ST_ROW: begin
            // read access or read-modify-write reads first
            if (!req_r.wr || rmw_r)
               state_nxt = pwa_pkg::ST_RD; // RQ2
            else
               state_nxt = pwa_pkg::ST_WR; // RQ1
         end
         pwa_pkg::ST_RD:  state_nxt = pwa_pkg::ST_LAT;
         pwa_pkg::ST_LAT: begin
            // processor reads end, rmw writes back
            if (req_r.wr)
               state_nxt = pwa_pkg::ST_WR; // RQ2
            else
               state_nxt = pwa_pkg::ST_END;
         end
         pwa_pkg::ST_WR:  state_nxt = pwa_pkg::ST_END;
         pwa_pkg::ST_SCR: state_nxt = pwa_pkg::ST_END;
         pwa_pkg::ST_END: state_nxt = pwa_pkg::ST_IDLE;
         default:         state_nxt = pwa_pkg::ST_IDLE;
      endcase
   end

   // sequencer state register
   always_ff @(posedge clk_sys) begin
      if (!resetn)
         state_r <= pwa_pkg::ST_IDLE;
      else
         state_r <= state_nxt; // RQ18
   end

   // request capture on acceptance
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         req_r <= '0;
         rmw_r <= 1'b0;
      end else if (take_req) begin
         req_r <= mem_cmd;
         rmw_r <= rmw_nxt;
      end
   end

   // busy flag for the processor port
   always_ff @(posedge clk_sys) begin
      if (!resetn)
         mem_busy <= 1'b0;
      else
         mem_busy <= state_nxt != pwa_pkg::ST_IDLE;
   end

   // strobe generator control from the next state
   always_comb begin
      stb_ctl.act = (state_nxt != pwa_pkg::ST_IDLE) &&
                    (state_nxt != pwa_pkg::ST_END);
      // screen cycles and word writes take the whole word
      stb_ctl.all = (state_nxt == pwa_pkg::ST_SCR) ||
                    (req_r.wr && req_r.word); // RQ15 RQ17
      stb_ctl.idx = req_r.idx;
      if (take_req) begin
         // entering row state: use the new request
         stb_ctl.all = mem_cmd.wr && mem_cmd.word;
         stb_ctl.idx = mem_cmd.idx;
      end
   end

   // row and column strobe generator
   pwa_strobe_gen u_strobe (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .ctl     (stb_ctl),
      .ras_n   (ram_ras_n),
      .cas_n   (ram_cas_n)
   ); // RQ18

   // write and output enable generator, aligned with state
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         ram_we_n <= 1'b1;
         ram_oe_n <= 1'b1;
      end else begin
         ram_we_n <= state_nxt != pwa_pkg::ST_WR; // RQ18
         // output enable over read, latch and screen
         ram_oe_n <= !(state_nxt == pwa_pkg::ST_RD ||
                       state_nxt == pwa_pkg::ST_LAT ||
                       state_nxt == pwa_pkg::ST_SCR);
      end
   end

   // latch clock from the enable generator
   assign lat_en = (state_r == pwa_pkg::ST_LAT); // RQ18

   // rmw request and bank selects
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         rmw_request      <= 1'b0;
         low_bank_select  <= 1'b0;
         high_bank_select <= 1'b0;
      end else begin
         // raised from row until the read completes
         rmw_request <= (state_nxt == pwa_pkg::ST_ROW && rmw_nxt) ||
                        ((state_nxt == pwa_pkg::ST_RD ||
                          state_nxt == pwa_pkg::ST_LAT) && rmw_r); // RQ19
         if (state_nxt == pwa_pkg::ST_SCR) begin
            // screen cycle: bank from refresh side
            low_bank_select  <= !scr_bank; // RQ19
            high_bank_select <= scr_bank;  // RQ19
         end else if (take_req) begin
            low_bank_select  <= !mem_cmd.bank;
            high_bank_select <= mem_cmd.bank;
         end else if (state_nxt == pwa_pkg::ST_IDLE ||
                      state_nxt == pwa_pkg::ST_END) begin
            low_bank_select  <= 1'b0;
            high_bank_select <= 1'b0;
         end
      end
   end

   // 16-to-1 read mux per plane
   always_comb begin
      for (int p = 0; p < 4; p++)
         mux_pix[p] = ram_rdata[p*16 + int'(req_r.idx)]; // RQ20
   end

   // read data latch
   always_ff @(posedge clk_sys) begin
      if (!resetn)
         rd_pix_r <= pwa_pkg::PIX_ZERO;
      else if (lat_en)
         rd_pix_r <= mux_pix; // RQ7
   end
   // latch is transparent while it captures, so rmw sees fresh data
   assign old_raw = lat_en ? mux_pix : rd_pix_r; // RQ7

   // processor byte select for writes
   assign wr_byte = req_r.idx[0] ? req_r.wdata[15:8]
                                 : req_r.wdata[7:0]; // RQ10

   // shifter and op
   assign new_pix = shift_new(wr_byte[3:0], shifter_ctl); // RQ11
   assign old_pix = shift_old(old_raw, shifter_ctl);     // RQ11
   assign alu_out = pix_op(op_sel, new_pix, old_pix);

   // protected planes rewrite the value read earlier
   assign wr_pix = (alu_out & ~wprot) | (old_raw & wprot); // RQ6 RQ22

   // ram write data, each plane bit across its 16 inputs
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         ram_wdata <= 64'h0;
      end else if (state_nxt == pwa_pkg::ST_WR) begin
         for (int p = 0; p < 4; p++)
            ram_wdata[p*16 +: 16] <= {16{wr_pix[p]}}; // RQ21
      end
   end

   // processor read answer, one pulse
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         mem_rdata  <= 16'h0000;
         mem_rvalid <= 1'b0;
      end else begin
         mem_rvalid <= 1'b0;
         if (state_r == pwa_pkg::ST_LAT && !req_r.wr) begin
            // pixel on both byte lanes, top nibbles zero
            mem_rdata  <= {4'h0, mux_pix, 4'h0, mux_pix}; // RQ8 RQ9
            mem_rvalid <= 1'b1;
         end
      end
   end

   // display shift register load at end of screen cycle
   always_ff @(posedge clk_sys) begin
      if (!resetn)
         disp_load <= 1'b0;
      else
         disp_load <= state_r == pwa_pkg::ST_SCR; // RQ15
   end
endmodule

// ===== bench/pwa_ram_model.sv
`timescale 1ns/10ps
module pwa_ram_model (
   input  wire logic        clk_sys,
   input  wire logic [63:0] ram_wdata,
   input  wire logic [3:0]  ram_ras_n,
   input  wire logic [3:0]  ram_cas_n,
   input  wire logic        ram_we_n,
   input  wire logic        ram_oe_n,
   input  wire logic        low_bank_select,
   input  wire logic        high_bank_select,
   output logic [63:0]      ram_rdata
);
   logic [63:0] mem [2] = '{64'h0, 64'h0};  // one word per bank, plane p at 16p
   logic        one_bank;                   // exactly one bank enabled

   assign one_bank = low_bank_select ^ high_bank_select;

   // store rams whose row and column strobes are both low
   always @(posedge clk_sys) begin
      for (int i = 0; i < 16; i++) begin
         if (!ram_we_n && one_bank && !ram_ras_n[i/4] && !ram_cas_n[i%4]) begin
            for (int p = 0; p < 4; p++) begin
               mem[high_bank_select][16*p+i] <= ram_wdata[16*p+i];
            end
         end
      end
   end

   // registered output; released lines show the inverse
   always @(posedge clk_sys) begin
      if (!ram_oe_n && one_bank) begin
         ram_rdata <= mem[high_bank_select];
      end else begin
         ram_rdata <= ~ram_rdata;
      end
   end
endmodule

// ===== bench/pwa_dp_asserts.sv
`timescale 1ns/10ps
module pwa_dp_asserts (
   input wire logic              clk_sys,
   input wire logic              resetn,
   input wire logic [3:0]        reg_addr,
   input wire logic [15:0]       reg_wdata,
   input wire logic              reg_wr,
   input wire logic              mem_req,
   input wire pwa_pkg::pwa_req_t mem_cmd,
   input wire logic              mem_busy,
   input wire logic [15:0]       mem_rdata,
   input wire logic              mem_rvalid,
   input wire logic              scr_req,
   input wire logic              scr_bank,
   input wire logic              disp_load,
   input wire logic [63:0]       ram_rdata,
   input wire logic [63:0]       ram_wdata,
   input wire logic [3:0]        ram_ras_n,
   input wire logic [3:0]        ram_cas_n,
   input wire logic              ram_we_n,
   input wire logic              ram_oe_n,
   input wire logic              low_bank_select,
   input wire logic              high_bank_select,
   input wire logic              rmw_request
);
   logic [15:0] ctrl_r;    // shadow of control register
   logic [3:0]  idx_r;     // pixel of last accepted request
   logic [3:0]  lat_px;    // mux pixel one cycle back
   logic        take;      // request accepted at this edge
   logic        need_rmw;  // control asks for a read first
   logic        rep_ok;    // every plane bit replicated

   function automatic logic [3:0] pix_of(input logic [63:0] r, input logic [3:0] i);
      return {r[48+i], r[32+i], r[16+i], r[i]};
   endfunction

   assign take     = mem_req && !mem_busy && !scr_req;
   assign need_rmw = (ctrl_r[7:4] != 4'h0) || (ctrl_r[2:0] inside {3'h1, 3'h2, 3'h3});
   assign rep_ok   = ram_wdata == {{16{ram_wdata[48]}}, {16{ram_wdata[32]}},
      {16{ram_wdata[16]}}, {16{ram_wdata[0]}}};

   // shadow control and accepted pixel index
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         ctrl_r <= 16'h0000;
         idx_r  <= 4'h0;
      end else begin
         if (reg_wr && reg_addr == pwa_pkg::REG_CTRL) begin
            ctrl_r <= reg_wdata;
         end
         if (take) begin
            idx_r <= mem_cmd.idx;
         end
      end
   end

   // mux view of the ram outputs, delayed one cycle
   always_ff @(posedge clk_sys) begin
      lat_px <= pix_of(ram_rdata, idx_r);
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   a_read_data_format: assert property (
      mem_rvalid |-> (mem_rdata[15:12] == 4'h0 && mem_rdata[7:4] == 4'h0
                      && mem_rdata[11:8] == mem_rdata[3:0]))
      else $error("read data layout wrong");
   a_screen_strobes: assert property (
      (scr_req && !mem_busy) |=> (ram_ras_n == 4'h0 && ram_cas_n == 4'h0 && !ram_oe_n
         && high_bank_select == $past(scr_bank) && low_bank_select == !$past(scr_bank))
         ##1 disp_load)
      else $error("screen cycle strobes or load wrong");
   a_byte_one_ram: assert property (
      (take && !(mem_cmd.wr && mem_cmd.word)) |=>
         (ram_ras_n == ~(4'h1 << $past(mem_cmd.idx[3:2]))
          && ram_cas_n == ~(4'h1 << $past(mem_cmd.idx[1:0]))
          && high_bank_select == $past(mem_cmd.bank)))
      else $error("byte access strobes wrong");
   a_word_all_strobes: assert property (
      (take && mem_cmd.wr && mem_cmd.word) |=> (ram_ras_n == 4'h0 && ram_cas_n == 4'h0))
      else $error("word write strobes wrong");
   a_plane_replicate: assert property (
      !ram_we_n |-> (rep_ok && mem_busy))
      else $error("plane data not replicated");
   a_rmw_sequence: assert property (
      (take && mem_cmd.wr && need_rmw) |=> rmw_request ##1 (rmw_request && !ram_oe_n)
         ##1 (rmw_request && !ram_oe_n) ##1 (!ram_we_n && !rmw_request))
      else $error("read modify write sequence wrong");
   a_write_only_seq: assert property (
      (take && mem_cmd.wr && !need_rmw) |=> (ram_oe_n && !rmw_request)
         ##1 (ram_oe_n && !ram_we_n) ##1 (ram_oe_n && ram_we_n))
      else $error("write only sequence wrong");
   a_read_pixel_mux: assert property (
      (take && !mem_cmd.wr) |-> ##4 (mem_rvalid && mem_rdata[3:0] == lat_px))
      else $error("read pixel not from mux");
endmodule

bind pwa_datapath pwa_dp_asserts u_pwa_dp_asserts (.*);

// ===== bench/testbench.sv
`timescale 1ns/10ps
module testbench;
   logic              clk_sys   = 1'b0;      // 25 MHz
   logic              resetn    = 1'b0;      // low for 20 cycles
   logic [3:0]        reg_addr  = 4'h0;
   logic [15:0]       reg_wdata = 16'h0000;
   logic              reg_wr    = 1'b0;
   logic              reg_rd    = 1'b0;
   logic              mem_req   = 1'b0;
   pwa_pkg::pwa_req_t mem_cmd   = '0;
   logic              scr_req   = 1'b0;
   logic              scr_bank  = 1'b0;
   logic [15:0]       reg_rdata, mem_rdata, d;
   logic              mem_busy, mem_rvalid, disp_load, ram_we_n, ram_oe_n;
   logic              low_bank_select, high_bank_select, rmw_request;
   logic [63:0]       ram_rdata, ram_wdata;
   logic [3:0]        ram_ras_n, ram_cas_n;
   logic [3:0]        shadow [2][16] = '{default: 4'h0};  // expected pixels
   int                error_cnt = 0;
   int                checked   = 0;

   always #20 clk_sys = ~clk_sys;

   pwa_datapath u_pwa_datapath (
      .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_req(mem_req),
      .mem_cmd(mem_cmd), .mem_busy(mem_busy), .mem_rdata(mem_rdata),
      .mem_rvalid(mem_rvalid), .scr_req(scr_req), .scr_bank(scr_bank),
      .disp_load(disp_load), .ram_rdata(ram_rdata), .ram_wdata(ram_wdata),
      .ram_ras_n(ram_ras_n), .ram_cas_n(ram_cas_n), .ram_we_n(ram_we_n),
      .ram_oe_n(ram_oe_n), .low_bank_select(low_bank_select),
      .high_bank_select(high_bank_select), .rmw_request(rmw_request));

   pwa_ram_model u_pwa_ram_model (
      .clk_sys(clk_sys), .ram_wdata(ram_wdata), .ram_ras_n(ram_ras_n),
      .ram_cas_n(ram_cas_n), .ram_we_n(ram_we_n), .ram_oe_n(ram_oe_n),
      .low_bank_select(low_bank_select), .high_bank_select(high_bank_select),
      .ram_rdata(ram_rdata));

   // expected pixel: shifter, op, plane protect
   function automatic logic [3:0] exp_pix(input logic [2:0] op, input logic [3:0] wp,
                                          input logic [3:0] sh, input logic [3:0] nw,
                                          input logic [3:0] od);
      logic [3:0] n, o, r;
      n = sh[2] ? (nw >> sh[1:0]) : (nw << sh[1:0]);
      o = od;
      if (sh[3]) begin
         n = (sh[2] | sh[1]) ? 4'hF : 4'h0;
         case (sh[2:0])
            3'h1: o = 4'hF;
            3'h3: o = 4'h0;
            3'h4: o = 4'hA;
            3'h5: o = 4'h5;
            3'h6: o = 4'hC;
            3'h7: o = 4'h3;
            default: o = od;
         endcase
      end
      case (op)
         3'h0: r = n;
         3'h1: r = o ^ n;
         3'h2: r = o | n;
         3'h3: r = o & n;
         3'h4: r = 4'h0;
         3'h5: r = 4'h5;
         3'h6: r = 4'hA;
         default: r = 4'hF;
      endcase
      return (r & ~wp) | (od & wp);
   endfunction

   // one comparison, counted
   task chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task reg_write(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   task reg_read(input logic [3:0] a, output logic [15:0] v);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(posedge clk_sys);
      v = reg_rdata;
   endtask

   // request pulse, count busy cycles, catch read data
   task mem_op(input pwa_pkg::pwa_req_t c, output int n, output logic [15:0] rd);
      rd = 16'hxxxx;
      n = 0;
      @(posedge clk_sys);
      mem_req <= 1'b1;
      mem_cmd <= c;
      @(posedge clk_sys);
      mem_req <= 1'b0;
      for (int w = 0; w < 20; w++) begin
         @(posedge clk_sys);
         if (mem_rvalid === 1'b1) rd = mem_rdata;
         if (mem_busy !== 1'b1) break;
         n++;
      end
   endtask

   task scr(input logic b);
      @(posedge clk_sys);
      scr_req <= 1'b1;
      scr_bank <= b;
      @(posedge clk_sys);
      scr_req <= 1'b0;
      repeat (3) @(posedge clk_sys);
   endtask

   // set mode, write pixel or word, read one back
   task one(input logic [2:0] op, input logic [3:0] sh);
      pwa_pkg::pwa_req_t c;
      logic [3:0]        wp, nw, res;
      logic [15:0]       rd;
      int                n;
      wp = ($urandom % 3 == 0) ? 4'($urandom) : 4'h0;
      reg_write(pwa_pkg::REG_CTRL, {sh, 4'h0, wp, 1'b0, op});
      c = pwa_pkg::pwa_req_t'(23'($urandom));
      c.wr = 1'b1;
      c.word = ($urandom % 12 == 0);
      nw = c.idx[0] ? c.wdata[11:8] : c.wdata[3:0];
      res = exp_pix(op, wp, sh, nw, shadow[c.bank][c.idx]);
      for (int j = 0; j < 16; j++) if (c.word || j == c.idx) shadow[c.bank][j] = res;
      mem_op(c, n, rd);
      chk(16'(n), (wp != 4'h0 || op inside {3'h1, 3'h2, 3'h3}) ? 16'h5 : 16'h3);
      c.wr = 1'b0;
      c.word = 1'b0;
      if ($urandom % 2) c.idx = 4'($urandom);
      mem_op(c, n, rd);
      chk(16'(n), 16'h4);
      chk(rd, {4'h0, shadow[c.bank][c.idx], 4'h0, shadow[c.bank][c.idx]});
   endtask

   task report_and_stop;
      $display("checks=%0d errors=%0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // registers, mode sweep, random traffic
   initial begin
      void'($urandom(94306));
      repeat (20) @(posedge clk_sys);
      resetn <= 1'b1;
      reg_read(pwa_pkg::REG_CTRL, d);
      chk(d, 16'h0000);
      reg_read(pwa_pkg::REG_STAT, d);
      chk(d, 16'h0000);
      reg_write(pwa_pkg::REG_CTRL, 16'hA053);
      reg_read(pwa_pkg::REG_CTRL, d);
      chk(d, 16'hA053);
      reg_write(pwa_pkg::REG_STAT, 16'hFFFF);
      reg_read(pwa_pkg::REG_STAT, d);
      chk(d, 16'h0000);
      reg_read(4'h8, d);
      chk(d, 16'h0000);
      $display("test registers done");
      for (int k = 0; k < 128; k++) begin
         one(3'(k), 4'(k >> 3));
         if (k % 8 == 0) scr(1'($urandom));
      end
      $display("test sweep done");
      for (int k = 0; k < 128; k++) begin
         one(3'($urandom), 4'($urandom));
         if (k % 16 == 0) scr(1'($urandom));
      end
      $display("test random done");
      report_and_stop();
   end

   // watchdog, well past the run length
   initial begin
      repeat (20000) @(posedge clk_sys);
      error_cnt++;
      report_and_stop();
   end
endmodule
